/* File: design/ptb_pkg.sv */
// Package of constants and types for the 8-bit period timer
package ptb_pkg;

   // Register byte offsets on APB
   localparam logic [11:0] PTB_OFS_COUNT = 12'h000;
   localparam logic [11:0] PTB_OFS_PERIOD = 12'h004;
   localparam logic [11:0] PTB_OFS_CONTROL = 12'h008;
   localparam logic [11:0] PTB_OFS_IRQ_FLAGS = 12'h00C;
   localparam logic [11:0] PTB_OFS_IRQ_ENABLES = 12'h010;
   localparam logic [11:0] PTB_OFS_IRQ_PRIORITY = 12'h014;

   // Reset values
   localparam logic [7:0] PTB_COUNT_RESET = 8'h00;
   localparam logic [7:0] PTB_PERIOD_RESET = 8'hFF;
   localparam logic [7:0] PTB_CONTROL_RESET = 8'h00;
   localparam logic [7:0] PTB_IRQ_RESET = 8'h00;
   localparam logic [7:0] PTB_COUNT_ZERO = 8'h00;

   // Control field positions
   localparam int PTB_CTL_PRE_LO = 0;
   localparam int PTB_CTL_PRE_HI = 1;
   localparam int PTB_CTL_RUN = 2;
   localparam int PTB_CTL_POST_LO = 3;
   localparam int PTB_CTL_POST_HI = 6;
   localparam logic [7:0] PTB_CTL_WRITE_MASK = 8'h7F;

   // Interrupt flag group bit of this timer
   localparam int PTB_IRQ_BIT = 1;
   localparam logic [7:0] PTB_IRQ_IMPL_MASK = 8'h02;

   // Prescaler terminal counts (ratio minus one)
   localparam logic [3:0] PTB_PRE_TC_1 = 4'h0;
   localparam logic [3:0] PTB_PRE_TC_4 = 4'h3;
   localparam logic [3:0] PTB_PRE_TC_16 = 4'hF;

   // Prescale select codes
   typedef enum logic [1:0]
   {
      PTB_PRE_DIV1 = 2'b00,
      PTB_PRE_DIV4 = 2'b01,
      PTB_PRE_DIV16A = 2'b10,
      PTB_PRE_DIV16B = 2'b11
   } ptb_prescale_type;

   // Control register layout
   typedef struct packed
   {
      logic unused7;
      logic [3:0] postscale_select;
      logic timer_run_enable;
      logic [1:0] prescale_select;
   } ptb_control_type;

   // Outputs to the compare unit and serial port
   typedef struct packed
   {
      logic period_match;
      logic postscale_event;
   } ptb_events_type;

endpackage

/* File: design/ptb_scaler.sv */
// Scaler counter that emits a pulse every terminal-count plus one inputs
`timescale 1ns/1ps
module ptb_scaler
#(
   parameter int WIDTH = 4
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // Control
   input wire logic clear,
   input wire logic step,
   input wire logic [WIDTH-1:0] terminal,
   // Result
   output logic pulse
);
   import ptb_pkg::*;

   logic [WIDTH-1:0] count;

   // Count steps; clear has priority since it restarts the ratio
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count <= '0;
      else if (clk_en)
      begin
         if (clear)
            count <= '0;
         else if (step)
         begin
            if (count >= terminal)
               count <= '0;
            else
               count <= count + 1'b1;
         end
      end
   end

   // Pulse on the step that completes the ratio
   assign pulse = step && !clear && (count >= terminal);

endmodule

/* File: design/ptb_timer.sv */
// Top of the 8-bit period timer with APB register access
//
// Overview of operation
// - An 8-bit count register is readable and writable over APB and is zero after reset.
// - The prescaler divides the tick by 1 for code 00, 4 for code 01, 16 for 1x.
// - Each period match goes through a postscaler of ratio code plus one that sets the flag.
// - Writes to the count or control register and reset clear both scaler counters.
// - A control write leaves the count value untouched.
// - The timer counts only while control bit 2 is set, which resets to zero.
// - The count steps from 00h each prescaled tick and returns to 00h after equalling the period.
// - An 8-bit period register is readable and writable and resets to FFh.
// - The pre-postscaler match is exported as a shift clock source for the serial port.
// - Control bit 7 reads zero and ignores writes.
// - The period match is exported as the time base for the compare unit PWM mode.
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
module ptb_timer
(
   // APB clock, reset and freeze
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Instruction-cycle tick, same clock domain
   input wire logic tick_en,
   // Event outputs
   output ptb_pkg::ptb_events_type events,
   output logic period_irq,
   output logic period_irq_priority
);
   import ptb_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   logic [7:0] period_timer_count;
   logic [7:0] period_compare_value;
   ptb_control_type period_timer_control;
   logic [7:0] irq_flag_group_one;
   logic [7:0] irq_enable_group_one;
   logic [7:0] irq_priority_group_one;

   logic access;
   logic wr;
   logic wr_count;
   logic wr_period;
   logic wr_control;
   logic wr_flags;
   logic wr_enables;
   logic wr_priority;
   logic addr_ok;
   logic scaler_clear;
   logic pre_pulse;
   logic match;
   logic post_pulse;
   logic [3:0] pre_terminal;
   logic [7:0] next_count;
   logic [7:0] rd_value;

   ////////////////////////////////////////////////////////////////////////////
   // APB decode

   // Zero-wait slave: every access completes in its first access cycle
   assign access = psel && penable && clk_en;
   assign wr = access && pwrite && pstrb[0];
   assign wr_count = wr && (paddr == PTB_OFS_COUNT);
   assign wr_period = wr && (paddr == PTB_OFS_PERIOD);
   assign wr_control = wr && (paddr == PTB_OFS_CONTROL);
   assign wr_flags = wr && (paddr == PTB_OFS_IRQ_FLAGS);
   assign wr_enables = wr && (paddr == PTB_OFS_IRQ_ENABLES);
   assign wr_priority = wr && (paddr == PTB_OFS_IRQ_PRIORITY);

   // Known addresses
   always_comb
   begin
      addr_ok = 1'b1;
      rd_value = 8'h00;
      unique case (paddr)
         PTB_OFS_COUNT: rd_value = period_timer_count;
         PTB_OFS_PERIOD: rd_value = period_compare_value;
         PTB_OFS_CONTROL: rd_value = period_timer_control & PTB_CTL_WRITE_MASK;
         PTB_OFS_IRQ_FLAGS: rd_value = irq_flag_group_one;
         PTB_OFS_IRQ_ENABLES: rd_value = irq_enable_group_one;
         PTB_OFS_IRQ_PRIORITY: rd_value = irq_priority_group_one;
         default: addr_ok = 1'b0;
      endcase
   end

   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   // Read data registered at the setup cycle so it is stable in access
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (clk_en && psel && !penable && !pwrite)
         prdata <= {24'h00_0000, rd_value};
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control and period registers

   // Bit 7 is never stored, so it cannot read back set
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         period_timer_control <= PTB_CONTROL_RESET;
      else if (clk_en && wr_control)
         period_timer_control <= pwdata[7:0] & PTB_CTL_WRITE_MASK;
   end

   // Period register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         period_compare_value <= PTB_PERIOD_RESET;
      else if (clk_en && wr_period)
         period_compare_value <= pwdata[7:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler

   // Both 1x codes give divide by 16
   always_comb
   begin
      unique case (ptb_prescale_type'(period_timer_control.prescale_select))
         PTB_PRE_DIV1: pre_terminal = PTB_PRE_TC_1;
         PTB_PRE_DIV4: pre_terminal = PTB_PRE_TC_4;
         PTB_PRE_DIV16A: pre_terminal = PTB_PRE_TC_16;
         PTB_PRE_DIV16B: pre_terminal = PTB_PRE_TC_16;
      endcase
   end

   // Count and control writes restart both scalers
   assign scaler_clear = wr_count || wr_control;

   ptb_scaler #(.WIDTH(4)) u_prescaler
   (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .clear(scaler_clear),
      .step(tick_en && period_timer_control.timer_run_enable),
      .terminal(pre_terminal),
      .pulse(pre_pulse)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Count register

   // Match fires on the tick after count equalled period
   assign match = pre_pulse && (period_timer_count == period_compare_value);

   always_comb
   begin
      next_count = period_timer_count;
      if (match)
         next_count = PTB_COUNT_ZERO;
      else if (pre_pulse)
         next_count = period_timer_count + 8'h01;
   end

   // Software write wins over a tick in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         period_timer_count <= PTB_COUNT_RESET;
      else if (clk_en)
      begin
         if (wr_count)
            period_timer_count <= pwdata[7:0];
         else
            period_timer_count <= next_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Postscaler

   ptb_scaler #(.WIDTH(4)) u_postscaler
   (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .clear(scaler_clear),
      .step(match),
      .terminal(period_timer_control.postscale_select),
      .pulse(post_pulse)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt flag, enable and priority

   // Set beats a write-one-to-clear in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_flag_group_one <= PTB_IRQ_RESET;
      else if (clk_en)
      begin
         if (post_pulse)
            irq_flag_group_one[PTB_IRQ_BIT] <= 1'b1;
         else if (wr_flags && pwdata[PTB_IRQ_BIT])
            irq_flag_group_one[PTB_IRQ_BIT] <= 1'b0;
      end
   end

   // Only this timer's bit exists in the group
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_enable_group_one <= PTB_IRQ_RESET;
      else if (clk_en && wr_enables)
         irq_enable_group_one <= pwdata[7:0] & PTB_IRQ_IMPL_MASK;
   end

   // Priority is only passed on, the interrupt controller uses it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_priority_group_one <= PTB_IRQ_RESET;
      else if (clk_en && wr_priority)
         irq_priority_group_one <= pwdata[7:0] & PTB_IRQ_IMPL_MASK;
   end

   assign period_irq = |(irq_flag_group_one & irq_enable_group_one);
   assign period_irq_priority = irq_priority_group_one[PTB_IRQ_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Event outputs, registered so downstream sees a clean copy of match and post_pulse one cycle later

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         events <= '0;
      else if (clk_en)
      begin
         events.period_match <= match;
         events.postscale_event <= post_pulse;
      end
   end

endmodule

/* File: verification/ptb_timer_properties.sv */
// Port checker for the period timer
`timescale 1ns/1ps
module ptb_timer_properties
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Timer side
   input wire logic tick_en,
   input wire ptb_pkg::ptb_events_type events,
   input wire logic period_irq
);
   import ptb_pkg::*;
   ////////////////////////////////////////
   // One domain, so one clock and one reset for all
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ready; psel && penable |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("access not ready");
   property p_unmapped; psel && penable && paddr > PTB_OFS_IRQ_PRIORITY |-> pslverr; endproperty
   a_unmapped: assert property (p_unmapped) else $error("no error response");
   property p_err_idle; !(psel && penable) |-> !pslverr; endproperty
   a_err_idle: assert property (p_err_idle) else $error("error outside access");
   property p_ctl_b7;
      psel && !penable && !pwrite && clk_en && paddr == PTB_OFS_CONTROL |=> !prdata[7];
   endproperty
   a_ctl_b7: assert property (p_ctl_b7) else $error("control bit 7 reads one");
   property p_wide_zero; prdata[31:8] == 24'h000000; endproperty
   a_wide_zero: assert property (p_wide_zero) else $error("upper read bits set");
   // Flag holds until software writes
   property p_flag_hold; period_irq && !(psel && penable && pwrite) |=> period_irq; endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("irq dropped alone");
   property p_post_on_match;
      events.postscale_event |-> events.period_match || $past(events.period_match);
   endproperty
   a_post_on_match: assert property (p_post_on_match) else $error("postscale w/o match");
   property p_irq_cause;
      $rose(period_irq) && !$past(psel && penable && pwrite)
         |-> (##[0:1] events.postscale_event) or $past(events.postscale_event);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq without event");
endmodule
bind ptb_timer ptb_timer_properties u_props (.*);

/* File: verification/ptb_far_end.sv */
// Model of the compare unit time base and serial shift clock user
`timescale 1ns/1ps
module ptb_far_end
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Timer events
   input wire ptb_pkg::ptb_events_type events,
   // Shift clock and time base count
   output logic shift_clk,
   output logic [15:0] match_cnt
);
   import ptb_pkg::*;
   ////////////////////////////////////////
   // Each match toggles the shift clock and steps the time base
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         shift_clk <= 1'b0;
         match_cnt <= 16'h0000;
      end
      else if (events.period_match)
      begin
         shift_clk <= ~shift_clk;
         match_cnt <= match_cnt + 16'h0001;
      end
   end
endmodule

/* File: verification/tb.sv */
// Self-checking bench of the period timer
`timescale 1ns/1ps
module tb;
   import ptb_pkg::*;
   logic pclk, presetn, clk_en, psel, penable, pwrite, tick_en, pready, pslverr;
   logic period_irq, period_irq_priority, shift_clk;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [15:0] match_cnt, m1;
   ptb_events_type events;
   int error_cnt, checks_done, n;
   int t[4];
   // Address, reset value, written value, value read back
   typedef struct {logic [11:0] a; logic [7:0] r, w, e;} ptb_row_type;
   ptb_row_type rows[7] = '{'{PTB_OFS_COUNT, 8'h00, 8'h5A, 8'h5A},
      '{PTB_OFS_PERIOD, 8'hFF, 8'h33, 8'h33}, '{PTB_OFS_CONTROL, 8'h00, 8'hF8, 8'h78},
      '{PTB_OFS_IRQ_FLAGS, 8'h00, 8'h00, 8'h00}, '{PTB_OFS_IRQ_ENABLES, 8'h00, 8'hFF, 8'h02},
      '{PTB_OFS_IRQ_PRIORITY, 8'h00, 8'hFF, 8'h02}, '{12'h018, 8'h00, 8'hFF, 8'h00}};
   ptb_timer DUT (.*);
   ptb_far_end u_far (.*);
   ////////////////////////////////////////
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task final_report;
      $display("Errors %0d, checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task tmo;
      error_cnt++;
      final_report();
   endtask
   // One APB transfer, released after the ready edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge pclk);
         i++;
      end
      while (pready !== 1'b1 && i < 20);
      if (i >= 20)
         tmo();
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Cycles until the next event pulse
   task automatic wev(input bit post);
      n = 0;
      while ((post ? events.postscale_event : events.period_match) !== 1'b1)
      begin
         @(posedge pclk);
         n++;
         if (n > 3000)
            tmo();
      end
   endtask
   // Second full interval, clear of any write in progress
   task automatic sp(input bit post);
      wev(post);
      @(posedge pclk);
      wev(post);
      @(posedge pclk);
      wev(post);
   endtask
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, error_cnt, checks_done} = '0;
      clk_en = 1'b1;
      tick_en = 1'b1;
      pstrb = 4'hF;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i])
      begin
         apb(1'b0, rows[i].a, 8'h00);
         chk(rd, rows[i].r);
         apb(1'b1, rows[i].a, rows[i].w);
         apb(1'b0, rows[i].a, 8'h00);
         chk(rd, rows[i].e);
      end
      // Every prescale code with period 3
      apb(1'b1, PTB_OFS_PERIOD, 8'h03);
      for (int c = 0; c < 4; c++)
      begin
         apb(1'b1, PTB_OFS_CONTROL, 8'h04 | 8'(c));
         sp(1'b0);
         chk(n + 1, 4 * (c == 0 ? 1 : c == 1 ? 4 : 16));
      end
      // Every postscale code, a match on each cycle
      apb(1'b1, PTB_OFS_PERIOD, 8'h00);
      for (int p = 0; p < 16; p++)
      begin
         apb(1'b1, PTB_OFS_CONTROL, 8'(p * 8 + 4));
         sp(1'b1);
         m1 = match_cnt;
         @(posedge pclk);
         wev(1'b1);
         chk(match_cnt - m1, p + 1);
         chk(shift_clk, match_cnt[0]);
      end
      // Flag is latched, held, masked and cleared
      apb(1'b1, PTB_OFS_CONTROL, 8'h00);
      apb(1'b1, PTB_OFS_IRQ_FLAGS, 8'h02);
      chk(period_irq, 1'b0);
      apb(1'b1, PTB_OFS_CONTROL, 8'h04);
      wev(1'b1);
      apb(1'b1, PTB_OFS_CONTROL, 8'h00);
      chk(period_irq, 1'b1);
      chk(period_irq_priority, 1'b1);
      apb(1'b1, PTB_OFS_IRQ_ENABLES, 8'h00);
      chk(period_irq, 1'b0);
      apb(1'b1, PTB_OFS_IRQ_ENABLES, 8'h02);
      apb(1'b0, PTB_OFS_IRQ_FLAGS, 8'h00);
      chk(rd, 32'h2);
      apb(1'b1, PTB_OFS_IRQ_FLAGS, 8'h02);
      chk(period_irq, 1'b0);
      // Match delay must not depend on the prescaler phase at the write
      apb(1'b1, PTB_OFS_PERIOD, 8'h02);
      apb(1'b1, PTB_OFS_CONTROL, 8'h06);
      for (int k = 0; k < 4; k++)
      begin
         apb(1'b1, PTB_OFS_COUNT, 8'h00);
         repeat (k[0] ? 9 : 3) @(posedge pclk);
         apb(1'b1, k < 2 ? PTB_OFS_COUNT : PTB_OFS_CONTROL, k < 2 ? 8'h00 : 8'h06);
         wev(1'b0);
         t[k] = n;
      end
      chk(t[1], t[0]);
      chk(t[3], t[2]);
      // Stopped timer keeps its count across a control write
      apb(1'b1, PTB_OFS_CONTROL, 8'h01);
      apb(1'b1, PTB_OFS_COUNT, 8'h40);
      apb(1'b1, PTB_OFS_CONTROL, 8'h7B);
      repeat (40) @(posedge pclk);
      apb(1'b0, PTB_OFS_COUNT, 8'h00);
      chk(rd, 32'h40);
      // Freeze: one tick lands after the count write, then nothing moves
      apb(1'b1, PTB_OFS_PERIOD, 8'hFF);
      apb(1'b1, PTB_OFS_CONTROL, 8'h04);
      apb(1'b1, PTB_OFS_COUNT, 8'h00);
      clk_en <= 1'b0;
      repeat (20) @(posedge pclk);
      clk_en <= 1'b1;
      apb(1'b0, PTB_OFS_COUNT, 8'h00);
      chk(rd, 32'h1);
      // Reset in mid-run restores the defaults
      apb(1'b1, PTB_OFS_CONTROL, 8'h04);
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, PTB_OFS_CONTROL, 8'h00);
      chk(rd, 32'h0);
      apb(1'b0, PTB_OFS_PERIOD, 8'h00);
      chk(rd, 32'hFF);
      // A write without its low byte strobe is dropped
      pstrb <= 4'hE;
      apb(1'b1, PTB_OFS_PERIOD, 8'h55);
      pstrb <= 4'hF;
      apb(1'b0, PTB_OFS_PERIOD, 8'h00);
      chk(rd, 32'hFF);
      final_report();
   end
endmodule
